// ===== bench/testbench.sv
`timescale 1ns/1ps
// ********************************************************************
// register bench
// ********************************************************************
module testbench;
   localparam logic [11:0] a_clr = tmi_pkg::TMI_OFS_EN_CLR;
   localparam logic [11:0] a_set = tmi_pkg::TMI_OFS_EN_SET;
   localparam logic [11:0] a_flg = tmi_pkg::TMI_OFS_FLAGS;
   localparam logic [31:0] vm = tmi_pkg::TMI_VALID_MASK;
   logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic enable_lock, counter_tick, irq;
   logic [11:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, irq_enables, irq_flags, m;
   tmi_pkg::tmi_evt_t evt;
   int errors, total_checks, bl[12], sh;
   tmi_irq_regs dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enable_lock(enable_lock), .evt(evt), .counter_tick(counter_tick),
      .irq(irq), .irq_enables(irq_enables), .irq_flags(irq_flags));
   // ********************************************************************
   // tasks
   // ********************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] er,
      input logic ee);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      if (!w)
      begin
         chk(prdata, er);
      end
      chk({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hf, 32'h0, 1'b0);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, 4'hf, e, 1'b0);
   endtask : rd
   task automatic pulse(input int b);
      logic [$bits(tmi_pkg::tmi_evt_t)-1:0] t;
      t = '0;
      t[b] = 1'b1;
      @(posedge core_clk);
      evt <= tmi_pkg::tmi_evt_t'(t);
      @(posedge core_clk);
      evt <= '0;
   endtask : pulse
   task automatic see(input logic [31:0] f, input logic i);
      @(negedge core_clk);
      chk(irq_flags, f);
      chk({31'h0, irq}, {31'h0, i});
   endtask : see
   task automatic conclude;
      if (errors == 0 && total_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // ********************************************************************
   // clock, watchdog, tests
   // ********************************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      #400000;
      errors++;
      conclude();
   end
   initial
   begin
      bl = '{0, 1, 2, 11, 12, 13, 14, 15, 16, 17, 18, 19};
      {rstn, psel, penable, pwrite, enable_lock} = '0;
      {paddr, pwdata, pstrb, evt, errors, total_checks} = '0;
      counter_tick = 1'b1;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      rd(a_set, 32'h0);
      rd(a_flg, 32'h0);
      wr(a_set, vm);
      rd(a_clr, vm);
      wr(a_clr, 32'h1);
      wr(a_set, 32'h0);
      wr(a_clr, 32'h0);
      rd(a_set, vm & ~32'h1);
      wr(a_clr, vm);
      for (int i = 0; i < 12; i++)
      begin
         m = 32'h1 << bl[i];
         sh = (bl[i] >= 11 && bl[i] < 16) ? bl[i] - 8 : bl[i];
         wr(a_set, m);
         pulse(sh);
         @(posedge core_clk);
         see(m, 1'b1);
         chk(irq_enables, m);
         wr(a_clr, m);
         see(m, 1'b0);
         wr(a_flg, 32'h0);
         rd(a_flg, m);
         wr(a_flg, m);
         rd(a_flg, 32'h0);
      end
      pulse(16);
      pulse(12);
      @(posedge core_clk);
      see(32'h0001_0008, 1'b0);
      pulse(8);
      @(posedge core_clk);
      see(32'h0000_0008, 1'b0);
      wr(a_flg, vm);
      fork
         wr(a_flg, 32'h1);
         pulse(0);
      join
      @(posedge core_clk);
      see(32'h1, 1'b0);
      wr(a_flg, 32'h1);
      enable_lock <= 1'b1;
      xfer(1'b1, a_set, 32'hf, 4'hf, 32'h0, 1'b1);
      rd(a_set, 32'h0);
      enable_lock <= 1'b0;
      xfer(1'b0, 12'h030, 32'h0, 4'hf, 32'h0, 1'b1);
      xfer(1'b1, a_set, vm, 4'h1, 32'h0, 1'b0);
      rd(a_clr, 32'h0000_000f);
      counter_tick <= 1'b0;
      pulse(1);
      repeat (3) @(posedge core_clk);
      see(32'h0, 1'b0);
      @(posedge core_clk);
      counter_tick <= 1'b1;
      @(posedge core_clk);
      see(32'h2, 1'b1);
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      see(32'h0, 1'b0);
      chk(irq_enables, 32'h0);
      rd(a_clr, 32'h0);
      conclude();
   end
endmodule : testbench

// ===== bench/tmi_irq_monitor.sv
`timescale 1ns/1ps
// ********************************************************************
// interrupt register checks
// ********************************************************************
module tmi_irq_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tmi_pkg::TMI_ADDR_W-1:0] paddr,
   input wire logic [tmi_pkg::TMI_DATA_W-1:0] pwdata,
   input wire logic [tmi_pkg::TMI_STRB_W-1:0] pstrb,
   input wire logic [tmi_pkg::TMI_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // events and state
   input wire logic enable_lock,
   input wire tmi_pkg::tmi_evt_t evt,
   input wire logic counter_tick,
   input wire logic irq,
   input wire logic [tmi_pkg::TMI_DATA_W-1:0] irq_enables,
   input wire logic [tmi_pkg::TMI_DATA_W-1:0] irq_flags
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic [31:0] wm;
   logic acc;
   logic first_q;
   assign wm = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
      {8{pstrb[0]}}};
   assign acc = psel && penable && pready && pwrite && !pslverr;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         first_q <= 1'b1;
      end
      else
      begin
         first_q <= 1'b0;
      end
   end
   AST_CLR: assert property (
      acc && paddr == tmi_pkg::TMI_OFS_EN_CLR
      |=> irq_enables == ($past(irq_enables) & ~$past(wm)))
      else $error("enable clear wrong");
   AST_SET: assert property (
      acc && paddr == tmi_pkg::TMI_OFS_EN_SET |=> irq_enables ==
      ($past(irq_enables) | ($past(wm) & tmi_pkg::TMI_VALID_MASK)))
      else $error("enable set wrong");
   AST_KEEP: assert property (
      !(acc && (paddr == tmi_pkg::TMI_OFS_EN_CLR
      || paddr == tmi_pkg::TMI_OFS_EN_SET)) |=> $stable(irq_enables))
      else $error("enable changed without write");
   AST_RSVD: assert property (
      ((irq_enables | irq_flags) & ~tmi_pkg::TMI_VALID_MASK) == '0)
      else $error("reserved bit set");
   AST_IRQ: assert property (
      irq == |(irq_flags & irq_enables))
      else $error("irq level wrong");
   AST_RST: assert property (
      first_q |-> irq_flags == '0 && irq_enables == '0 && !irq)
      else $error("state not clear after reset");
   AST_RISE: assert property (
      evt.wrap_around && counter_tick |-> ##[1:2] irq_flags[0])
      else $error("wrap flag not raised");
   AST_ERR: assert property (
      |(evt.channel_capture & irq_flags[19:16]) |-> ##[1:2] irq_flags[3])
      else $error("error flag not raised");
   AST_W1C: assert property (
      acc && paddr == tmi_pkg::TMI_OFS_FLAGS && evt == '0
      && $past(evt) == '0 |=> (irq_flags & $past(wm)) == '0)
      else $error("flag not cleared");
   cover property ($rose(irq));
   cover property (pslverr);
   cover property ($rose(irq_flags[3]));
endmodule : tmi_irq_monitor

bind tmi_irq_regs tmi_irq_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .enable_lock(enable_lock), .evt(evt),
   .counter_tick(counter_tick), .irq(irq), .irq_enables(irq_enables),
   .irq_flags(irq_flags));

// ===== design/tmi_apb_slave.sv
`timescale 1ns/1ps
// ********************************************************************
// apb handshake and decode
// ********************************************************************
module tmi_apb_slave (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // bus
   input wire tmi_pkg::tmi_apb_req_t req,
   input wire logic enable_lock,
   output logic pready,
   output logic pslverr,
   // towards register file
   output logic setup,
   output tmi_pkg::tmi_sel_t setup_sel,
   output tmi_pkg::tmi_sel_t sel_q,
   output logic wr_en
);
   logic bad_d;

   always_comb
   begin
      setup = req.psel & ~req.penable;
      setup_sel = tmi_pkg::tmi_decode(req.paddr);
      bad_d = (setup_sel == tmi_pkg::TMI_SEL_NONE) |
         (req.pwrite & enable_lock &
          (setup_sel != tmi_pkg::TMI_SEL_FLAGS));
      wr_en = req.psel & req.penable & pready & req.pwrite & ~pslverr;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         pslverr <= 1'b0;
      else
         pslverr <= setup & bad_d;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         sel_q <= tmi_pkg::TMI_SEL_NONE;
      else if (setup)
         sel_q <= setup_sel;
   end
endmodule : tmi_apb_slave

// ===== design/tmi_irq_regs.sv
// Summary of operation
// - clear view write one disables source
// - set view write one enables source
// - written zeros leave enables unchanged
// - both views read one shared state
// - one means enabled or pending
// - channels 19:16, faults 15:11, events 3:0
// - reserved bits read zero, software writes zero
// - flag register shares the enable layout
// - flags and enables reset to zero
// - flags rise on following counter tick
// - flag write one clears, zero ignored
// - capture onto pending channel raises error

`timescale 1ns/1ps

module tmi_irq_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tmi_pkg::TMI_ADDR_W-1:0] paddr,
   input wire logic [tmi_pkg::TMI_DATA_W-1:0] pwdata,
   input wire logic [tmi_pkg::TMI_STRB_W-1:0] pstrb,
   output logic [tmi_pkg::TMI_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // write protection of the enable views
   input wire logic enable_lock,
   // timer datapath events
   input wire tmi_pkg::tmi_evt_t evt,
   input wire logic counter_tick,
   // interrupt and state
   output logic irq,
   output logic [tmi_pkg::TMI_DATA_W-1:0] irq_enables,
   output logic [tmi_pkg::TMI_DATA_W-1:0] irq_flags
);

   // ********************************************************************
   // declarations
   // ********************************************************************
   tmi_pkg::tmi_apb_req_t req;
   tmi_pkg::tmi_sel_t setup_sel;
   tmi_pkg::tmi_sel_t sel_q;
   logic setup;
   logic wr_en;
   logic [tmi_pkg::TMI_DATA_W-1:0] wr_word;
   logic [tmi_pkg::TMI_DATA_W-1:0] en_set_vec;
   logic [tmi_pkg::TMI_DATA_W-1:0] en_clr_vec;
   logic [tmi_pkg::TMI_DATA_W-1:0] enable_d;
   logic [tmi_pkg::TMI_DATA_W-1:0] enable_q;
   logic [tmi_pkg::TMI_DATA_W-1:0] raw_word;
   logic [tmi_pkg::TMI_DATA_W-1:0] pend_clr;
   logic [tmi_pkg::TMI_DATA_W-1:0] pend_d;
   logic [tmi_pkg::TMI_DATA_W-1:0] pend_q;
   logic [tmi_pkg::TMI_DATA_W-1:0] tick_word;
   logic [tmi_pkg::TMI_DATA_W-1:0] flag_set;
   logic [tmi_pkg::TMI_DATA_W-1:0] flag_clr;
   logic [tmi_pkg::TMI_DATA_W-1:0] sw_flag_clr;
   logic [tmi_pkg::TMI_DATA_W-1:0] read_clr;
   logic [tmi_pkg::TMI_DATA_W-1:0] flags_d;
   logic [tmi_pkg::TMI_DATA_W-1:0] flags_q;
   logic [tmi_pkg::TMI_DATA_W-1:0] rd_word;
   logic [tmi_pkg::TMI_DATA_W-1:0] rd_masked;
   logic [tmi_pkg::TMI_CHAN_N-1:0] chan_word;
   logic [tmi_pkg::TMI_CHAN_N-1:0] chan_flagged;
   logic [tmi_pkg::TMI_CHAN_N-1:0] clash_vec;
   logic capture_clash;
   genvar c;
   logic irq_d;
   logic irq_q;

   // ********************************************************************
   // helpers
   // ********************************************************************
   // an accepted write access to one of the views
   function automatic logic view_written(
      input logic wr,
      input tmi_pkg::tmi_sel_t sel,
      input tmi_pkg::tmi_sel_t want
   );
      return wr && (sel == want);
   endfunction : view_written

   // ********************************************************************
   // bus slave
   // ********************************************************************
   always_comb
   begin
      req.psel = psel;
      req.penable = penable;
      req.pwrite = pwrite;
      req.paddr = paddr;
      req.pwdata = pwdata;
      req.pstrb = pstrb;
   end

   tmi_apb_slave u_apb (
      .core_clk(core_clk),
      .rstn(rstn),
      .req(req),
      .enable_lock(enable_lock),
      .pready(pready),
      .pslverr(pslverr),
      .setup(setup),
      .setup_sel(setup_sel),
      .sel_q(sel_q),
      .wr_en(wr_en)
   );

   // ********************************************************************
   // write data shaping
   // ********************************************************************
   // reserved positions never reach the state
   always_comb
   begin
      wr_word = req.pwdata & tmi_pkg::tmi_lane_mask(req.pstrb) &
         tmi_pkg::TMI_VALID_MASK;
   end

   // ********************************************************************
   // enable views
   // ********************************************************************
   // set view strobe
   always_comb
   begin
      en_set_vec = tmi_pkg::TMI_ZERO_WORD;
      if (view_written(wr_en, sel_q, tmi_pkg::TMI_SEL_SET))
      begin
         en_set_vec = wr_word;
      end
   end

   // clear view strobe
   always_comb
   begin
      en_clr_vec = tmi_pkg::TMI_ZERO_WORD;
      if (view_written(wr_en, sel_q, tmi_pkg::TMI_SEL_CLR))
      begin
         en_clr_vec = wr_word;
      end
   end

   // zero bits pass the old value through
   always_comb
   begin
      enable_d = (enable_q | en_set_vec) & ~en_clr_vec;
      enable_d = enable_d & tmi_pkg::TMI_VALID_MASK;
   end

   // one shared store behind both views
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         enable_q <= tmi_pkg::TMI_RESET_WORD;
      else
         enable_q <= enable_d;
   end

   // ********************************************************************
   // error detection
   // ********************************************************************
   // a flag still pending, or already on its way, turns a capture into an error
   generate
      for (c = 0; c < tmi_pkg::TMI_CHAN_N; c++)
      begin : g_chan
         always_comb
         begin
            chan_flagged[c] = flags_q[tmi_pkg::TMI_CHAN_LSB + c] |
               pend_q[tmi_pkg::TMI_CHAN_LSB + c];
            clash_vec[c] = evt.channel_capture[c] & chan_flagged[c];
         end
      end
   endgenerate

   always_comb
   begin
      capture_clash = |clash_vec;
   end

   // ********************************************************************
   // event gathering
   // ********************************************************************
   // a capture also marks its channel
   always_comb
   begin
      chan_word = evt.channel_hit | evt.channel_capture;
   end

   always_comb
   begin
      raw_word = tmi_pkg::TMI_ZERO_WORD;
      raw_word[tmi_pkg::TMI_CHAN_LSB +: tmi_pkg::TMI_CHAN_N] =
         chan_word;
      raw_word[tmi_pkg::TMI_HARD1_BIT] = evt.hard_stop_one;
      raw_word[tmi_pkg::TMI_HARD0_BIT] = evt.hard_stop_zero;
      raw_word[tmi_pkg::TMI_SOFTB_BIT] = evt.soft_stop_b;
      raw_word[tmi_pkg::TMI_SOFTA_BIT] = evt.soft_stop_a;
      raw_word[tmi_pkg::TMI_DEBUG_BIT] = evt.debug_halt_fault;
      raw_word[tmi_pkg::TMI_ERR_BIT] = capture_clash;
      raw_word[tmi_pkg::TMI_CYCLE_BIT] = evt.cycle_event;
      raw_word[tmi_pkg::TMI_RESTART_BIT] = evt.restart_event;
      raw_word[tmi_pkg::TMI_WRAP_BIT] = evt.wrap_around;
   end

   // ********************************************************************
   // counter tick stage
   // ********************************************************************
   // events wait here for the next counter clock tick
   always_comb
   begin
      tick_word = {tmi_pkg::TMI_DATA_W{counter_tick}};
   end

   // a ticked event leaves the stage as it enters the flags
   always_comb
   begin
      pend_clr = pend_q & tick_word;
   end

   tmi_sticky_reg #(
      .W(tmi_pkg::TMI_DATA_W),
      .RST_VAL(tmi_pkg::TMI_RESET_WORD)
   ) u_pend (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_vec(raw_word),
      .clr_vec(pend_clr),
      .keep_mask(tmi_pkg::TMI_VALID_MASK),
      .val_d(pend_d),
      .val_q(pend_q)
   );

   // ********************************************************************
   // flag register
   // ********************************************************************
   always_comb
   begin
      flag_set = pend_q & tick_word;
   end

   always_comb
   begin
      sw_flag_clr = tmi_pkg::TMI_ZERO_WORD;
      if (view_written(wr_en, sel_q, tmi_pkg::TMI_SEL_FLAGS))
      begin
         sw_flag_clr = wr_word;
      end
   end

   // reading a captured value frees its channel flag
   always_comb
   begin
      read_clr = tmi_pkg::TMI_ZERO_WORD;
      read_clr[tmi_pkg::TMI_CHAN_LSB +: tmi_pkg::TMI_CHAN_N] =
         evt.channel_read;
   end

   always_comb
   begin
      flag_clr = sw_flag_clr | read_clr;
   end

   // set wins inside the bit array
   tmi_sticky_reg #(
      .W(tmi_pkg::TMI_DATA_W),
      .RST_VAL(tmi_pkg::TMI_RESET_WORD)
   ) u_flags (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_vec(flag_set),
      .clr_vec(flag_clr),
      .keep_mask(tmi_pkg::TMI_VALID_MASK),
      .val_d(flags_d),
      .val_q(flags_q)
   );

   // ********************************************************************
   // read data
   // ********************************************************************
   always_comb
   begin
      case (setup_sel)
         tmi_pkg::TMI_SEL_CLR: rd_word = enable_q;
         tmi_pkg::TMI_SEL_SET: rd_word = enable_q;
         tmi_pkg::TMI_SEL_FLAGS: rd_word = flags_q;
         default: rd_word = tmi_pkg::TMI_ZERO_WORD;
      endcase
   end

   // reserved positions read as zero
   always_comb
   begin
      rd_masked = rd_word & tmi_pkg::TMI_VALID_MASK;
   end

   // sampled in the setup cycle, held through access
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         prdata <= tmi_pkg::TMI_ZERO_WORD;
      else if (setup && !req.pwrite)
         prdata <= rd_masked;
   end

   // ********************************************************************
   // interrupt line
   // ********************************************************************
   always_comb
   begin
      irq_d = |(flags_d & enable_d);
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   always_comb
   begin
      irq = irq_q;
   end

   always_comb
   begin
      irq_enables = enable_q;
   end

   always_comb
   begin
      irq_flags = flags_q;
   end

endmodule : tmi_irq_regs

// ===== design/tmi_pkg.sv
// ********************************************************************
// register map and layout
// ********************************************************************
package tmi_pkg;
   localparam int TMI_DATA_W = 32;
   localparam int TMI_ADDR_W = 12;
   localparam int TMI_STRB_W = 4;
   localparam int TMI_LANE_W = 8;
   localparam int TMI_CHAN_N = 4;

   // byte offsets of the three views
   localparam logic [TMI_ADDR_W-1:0] TMI_OFS_EN_CLR = 12'h024;
   localparam logic [TMI_ADDR_W-1:0] TMI_OFS_EN_SET = 12'h028;
   localparam logic [TMI_ADDR_W-1:0] TMI_OFS_FLAGS = 12'h02c;

   localparam logic [TMI_DATA_W-1:0] TMI_RESET_WORD = 32'h0000_0000;
   localparam logic [TMI_DATA_W-1:0] TMI_VALID_MASK = 32'h000f_f80f;
   localparam logic [TMI_DATA_W-1:0] TMI_ZERO_WORD = 32'h0000_0000;

   // bit positions
   localparam int TMI_CHAN_LSB = 16;
   localparam int TMI_HARD1_BIT = 15;
   localparam int TMI_HARD0_BIT = 14;
   localparam int TMI_SOFTB_BIT = 13;
   localparam int TMI_SOFTA_BIT = 12;
   localparam int TMI_DEBUG_BIT = 11;
   localparam int TMI_ERR_BIT = 3;
   localparam int TMI_CYCLE_BIT = 2;
   localparam int TMI_RESTART_BIT = 1;
   localparam int TMI_WRAP_BIT = 0;

   // ********************************************************************
   // carriers
   // ********************************************************************
   typedef struct packed {
      logic [TMI_CHAN_N-1:0] channel_hit;
      logic [TMI_CHAN_N-1:0] channel_capture;
      logic [TMI_CHAN_N-1:0] channel_read;
      logic hard_stop_one;
      logic hard_stop_zero;
      logic soft_stop_b;
      logic soft_stop_a;
      logic debug_halt_fault;
      logic cycle_event;
      logic restart_event;
      logic wrap_around;
   } tmi_evt_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [TMI_ADDR_W-1:0] paddr;
      logic [TMI_DATA_W-1:0] pwdata;
      logic [TMI_STRB_W-1:0] pstrb;
   } tmi_apb_req_t;

   typedef enum logic [1:0] {
      TMI_SEL_NONE,
      TMI_SEL_CLR,
      TMI_SEL_SET,
      TMI_SEL_FLAGS
   } tmi_sel_t;

   // ********************************************************************
   // helpers
   // ********************************************************************
   function automatic tmi_sel_t tmi_decode(
      input logic [TMI_ADDR_W-1:0] addr
   );
      tmi_sel_t s;
      case (addr)
         TMI_OFS_EN_CLR: s = TMI_SEL_CLR;
         TMI_OFS_EN_SET: s = TMI_SEL_SET;
         TMI_OFS_FLAGS: s = TMI_SEL_FLAGS;
         default: s = TMI_SEL_NONE;
      endcase
      return s;
   endfunction : tmi_decode

   function automatic logic [TMI_DATA_W-1:0] tmi_lane_mask(
      input logic [TMI_STRB_W-1:0] strb
   );
      logic [TMI_DATA_W-1:0] m;
      m = TMI_ZERO_WORD;
      for (int i = 0; i < TMI_STRB_W; i++)
      begin
         m[i*TMI_LANE_W +: TMI_LANE_W] = {TMI_LANE_W{strb[i]}};
      end
      return m;
   endfunction : tmi_lane_mask
endpackage : tmi_pkg

// ===== design/tmi_sticky_reg.sv
`timescale 1ns/1ps
// ********************************************************************
// sticky bit array, set beats clear
// ********************************************************************
module tmi_sticky_reg #(
   parameter int W = 32,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control
   input wire logic [W-1:0] set_vec,
   input wire logic [W-1:0] clr_vec,
   input wire logic [W-1:0] keep_mask,
   // state
   output logic [W-1:0] val_d,
   output logic [W-1:0] val_q
);
   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_bit
         always_comb
         begin
            val_d[b] = keep_mask[b] &
               (set_vec[b] | (val_q[b] & ~clr_vec[b]));
         end
         always_ff @(posedge core_clk or negedge rstn)
         begin
            if (!rstn)
               val_q[b] <= RST_VAL[b];
            else
               val_q[b] <= val_d[b];
         end
      end
   endgenerate
endmodule : tmi_sticky_reg
